// File: eep_consts.vh
// constants for the edid emulation and hdcp policy block
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH

// register byte offsets
`define EEP_REG_CTRL 8'h00
`define EEP_REG_ROUTE 8'h04
`define EEP_REG_EMU 8'h08
`define EEP_REG_CMD 8'h0C
`define EEP_REG_STATUS 8'h10
`define EEP_REG_LIB_ADDR 8'h14
`define EEP_REG_LIB_DATA 8'h18
`define EEP_REG_EDID_ADDR 8'h1C
`define EEP_REG_EDID_DATA 8'h20

// field positions
`define EEP_CTRL_HDCP_LSB 0
`define EEP_CTRL_MODE_LSB 4
`define EEP_CMD_INPUT_LSB 0
`define EEP_CMD_START_BIT 2
`define EEP_EMU_DYN_BIT 3

// reset values
`define EEP_CTRL_RST 6'h0F
`define EEP_ROUTE_RST 4'h4
`define EEP_EMU_RST 16'h0000

// edid layout: 128-byte base block plus one 128-byte extension
`define EEP_EDID_BYTES 256
`define EEP_BASE_BYTES 128
`define EEP_HDR0 8'h00
`define EEP_HDR1 8'hFF

// timing
`define EEP_CLK_NS 8
`define EEP_TICK_NS 1000000
`define EEP_HPD_MS 2000

`endif

// File: eep_hpd_timer.v
// hot-plug low pulse timer for one input
`timescale 1ns/1ps
`include "eep_consts.vh"

module eep_hpd_timer (
  input wire clk,
  input wire rstn,
  input wire tick_ms,
  input wire restart,
  output reg hpd
);

  reg [10:0] remain;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain <= 11'h000;
      hpd <= 1'b1;
    end else if (restart) begin
      // a new change restarts the full low period
      remain <= 11'd`EEP_HPD_MS; // R13
      hpd <= 1'b0; // R05
    end else if (remain != 11'h000) begin
      if (tick_ms) begin
        remain <= remain - 11'h001; // R13
        if (remain == 11'h001) begin
          hpd <= 1'b1;
        end
      end
    end
  end

endmodule // eep_hpd_timer

// File: eep_top.v
// edid emulation stores, sink capture, hot-plug and hdcp gating
`timescale 1ns/1ps
`include "eep_consts.vh"

// Behaviour
// R01 - each of the four inputs has its own edid store and read path, and loading one never touches another; the code reads all four through one ddc port.
// R02 - a valid edid captured from each output's display is kept in a store that no reset or unplug clears.
// R03 - an input loads either a library entry (static) or the last captured edid of a chosen output (dynamic).
// R04 - a dynamic input reloads by itself when its followed output captures a new edid, but only a valid one.
// R05 - whenever an input's edid is reloaded its hot-plug line goes low for 2 seconds.
// R06 - reloading an edid needs no disconnect; sources may keep reading the store during a reload.
// R07 - each store holds a 128-byte base block and a 128-byte extension block.
// R08 - the source reads the edid over the display data channel and withholds video without one.
// R09 - an encrypted stream is never sent to a non-compliant display; that output raises an alert instead.
// R10 - an input with hdcp disabled reports itself as not hdcp capable.
// R11 - an output in automatic mode sends unencrypted content unencrypted when its input has hdcp disabled.
// R12 - a source with protected content withholds it from a non-capable input and encrypts otherwise.
// R13 - the hot-plug low period is counted on the system clock and restarts on another change meanwhile.
module eep_top #(
  parameter TICK_CYCLES = `EEP_TICK_NS / `EEP_CLK_NS
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata,
  input wire ddc_rd,
  input wire [1:0] ddc_input,
  input wire [7:0] ddc_addr,
  output reg [7:0] ddc_data,
  input wire cap_valid,
  input wire cap_output,
  input wire [7:0] cap_addr,
  input wire [7:0] cap_data,
  input wire cap_done,
  output reg cap_ready,
  output wire [3:0] hpd,
  output reg [3:0] src_hdcp_capable,
  input wire [3:0] in_encrypted,
  input wire [1:0] sink_hdcp_ok,
  output reg [1:0] out_encrypt,
  output reg [1:0] out_alert
);

  localparam ST_IDLE = 2'b01;
  localparam ST_COPY = 2'b10;
  localparam SRC_LIB = 2'd0;
  localparam SRC_SINK = 2'd1;
  localparam SRC_STG = 2'd2;
  localparam [5:0] CTRL_RST = `EEP_CTRL_RST;

  // edid memories; none is reset, the sink store models the non-volatile copy
  reg [7:0] in_store [0:4*`EEP_EDID_BYTES-1]; // R01 R07
  reg [7:0] sink_store [0:2*`EEP_EDID_BYTES-1]; // R02
  reg [7:0] lib_store [0:4*`EEP_EDID_BYTES-1];
  reg [7:0] stg_store [0:`EEP_EDID_BYTES-1];

  reg [3:0] hdcp_en;
  reg [1:0] out_always;
  reg [3:0] route;
  reg [15:0] emu_cfg;
  reg [9:0] lib_addr;
  reg [10:0] edid_addr;
  reg [3:0] pending;
  reg [3:0] next_pending;
  reg [1:0] sink_valid;
  reg [1:0] state;
  reg [1:0] cp_src;
  reg [1:0] cp_src_idx;
  reg cp_dst_sink;
  reg [1:0] cp_dst_idx;
  reg [7:0] cp_idx;
  reg [7:0] cp_byte;
  reg [3:0] hpd_restart;
  reg [3:0] dyn_set;
  reg commit_req;
  reg commit_out;
  reg [7:0] cap_sum;
  reg hdr0_ok;
  reg hdr1_ok;
  reg [16:0] tick_cnt;
  reg tick_ms;
  reg [3:0] enc_meta;
  reg [3:0] enc_sync;
  reg [1:0] sink_meta;
  reg [1:0] sink_sync;
  integer k;
  integer j;

  function [1:0] first_one;
    input [3:0] v;
    begin
      if (v[0]) first_one = 2'd0;
      else if (v[1]) first_one = 2'd1;
      else if (v[2]) first_one = 2'd2;
      else first_one = 2'd3;
    end
  endfunction

  function [3:0] emu_field;
    input [15:0] cfg;
    input [1:0] idx;
    begin
      emu_field = cfg[idx*4 +: 4];
    end
  endfunction

  wire sw_wr = bus_wr;
  wire cmd_go = sw_wr && (bus_addr == `EEP_REG_CMD) && bus_wdata[`EEP_CMD_START_BIT];
  wire copy_last = (state == ST_COPY) && (cp_idx == 8'hFF);
  wire [1:0] pick = first_one(pending);
  wire [3:0] pick_cfg = emu_field(emu_cfg, pick);

  // source byte for the copy engine
  always @* begin
    case (cp_src)
      SRC_LIB: cp_byte = lib_store[{cp_src_idx, cp_idx}];
      SRC_SINK: cp_byte = sink_store[{cp_src_idx[0], cp_idx}];
      default: cp_byte = stg_store[cp_idx];
    endcase
  end

  // inputs whose dynamic emulation follows the output just committed
  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      dyn_set[k] = copy_last && cp_dst_sink && emu_cfg[k*4 + `EEP_EMU_DYN_BIT] &&
                   (emu_cfg[k*4] == cp_dst_idx[0]); // R04
    end
  end

  // a new request wins over the clear of the one being served
  always @* begin
    next_pending = pending;
    if ((state == ST_IDLE) && !commit_req && (pending != 4'h0)) begin
      next_pending[pick] = 1'b0;
    end
    if (cmd_go) begin
      next_pending[bus_wdata[`EEP_CMD_INPUT_LSB +: 2]] = 1'b1; // R03
    end
    next_pending = next_pending | dyn_set; // R04
  end

  // memory writes: engine, capture staging and library loading
  always @(posedge clk) begin
    if (state == ST_COPY) begin
      if (cp_dst_sink) begin
        sink_store[{cp_dst_idx[0], cp_idx}] <= cp_byte; // R02
      end else begin
        in_store[{cp_dst_idx, cp_idx}] <= cp_byte; // R01
      end
    end
    if (cap_valid) begin
      stg_store[cap_addr] <= cap_data;
    end
    if (sw_wr && (bus_addr == `EEP_REG_LIB_DATA)) begin
      lib_store[lib_addr] <= bus_wdata[7:0];
    end
  end

  // source read port stays live while a reload is in progress
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ddc_data <= 8'h00;
    end else if (ddc_rd) begin
      ddc_data <= in_store[{ddc_input, ddc_addr}]; // R06 R08
    end
  end

  // capture checks header and base checksum before committing
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_sum <= 8'h00;
      hdr0_ok <= 1'b0;
      hdr1_ok <= 1'b0;
      commit_req <= 1'b0;
      commit_out <= 1'b0;
      cap_ready <= 1'b0;
    end else begin
      if (cap_valid) begin
        if (cap_addr == 8'h00) begin
          cap_sum <= cap_data;
          hdr0_ok <= (cap_data == `EEP_HDR0);
        end else if (cap_addr < 8'd`EEP_BASE_BYTES) begin
          cap_sum <= cap_sum + cap_data;
        end
        if (cap_addr == 8'h01) begin
          hdr1_ok <= (cap_data == `EEP_HDR1);
        end
      end
      if (cap_done && (cap_sum == 8'h00) && hdr0_ok && hdr1_ok) begin
        commit_req <= 1'b1; // R04
        commit_out <= cap_output;
      end else if ((state == ST_IDLE) && commit_req) begin
        commit_req <= 1'b0;
      end
      // staging is busy until its copy finishes
      cap_ready <= !commit_req && !(cap_done) &&
                   !((state == ST_COPY) && (cp_src == SRC_STG));
    end
  end

  // copy engine: commits first, then pending input reloads
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cp_src <= SRC_LIB;
      cp_src_idx <= 2'd0;
      cp_dst_sink <= 1'b0;
      cp_dst_idx <= 2'd0;
      cp_idx <= 8'h00;
      pending <= 4'h0;
      hpd_restart <= 4'h0;
      sink_valid <= 2'b00;
    end else begin
      pending <= next_pending;
      hpd_restart <= 4'h0;
      case (state)
        ST_IDLE: begin
          cp_idx <= 8'h00;
          if (commit_req) begin
            cp_src <= SRC_STG;
            cp_dst_sink <= 1'b1;
            cp_dst_idx <= {1'b0, commit_out};
            state <= ST_COPY;
          end else if (pending != 4'h0) begin
            cp_dst_sink <= 1'b0;
            cp_dst_idx <= pick;
            if (pick_cfg[`EEP_EMU_DYN_BIT]) begin
              cp_src <= SRC_SINK; // R03
              cp_src_idx <= {1'b0, pick_cfg[0]};
            end else begin
              cp_src <= SRC_LIB; // R03
              cp_src_idx <= pick_cfg[1:0];
            end
            state <= ST_COPY;
          end
        end
        ST_COPY: begin
          cp_idx <= cp_idx + 8'h01;
          if (copy_last) begin
            state <= ST_IDLE;
            if (cp_dst_sink) begin
              sink_valid[cp_dst_idx[0]] <= 1'b1;
            end else begin
              hpd_restart[cp_dst_idx] <= 1'b1; // R05
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // millisecond enable for the hot-plug timers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 17'h0_0000;
      tick_ms <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[16:0] - 17'h0_0001) begin
      tick_cnt <= 17'h0_0000;
      tick_ms <= 1'b1; // R13
    end else begin
      tick_cnt <= tick_cnt + 17'h0_0001;
      tick_ms <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_hpd
      eep_hpd_timer u_hpd (
        .clk(clk),
        .rstn(rstn),
        .tick_ms(tick_ms),
        .restart(hpd_restart[g]),
        .hpd(hpd[g])
      );
    end
  endgenerate

  // registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hdcp_en <= CTRL_RST[3:0];
      out_always <= CTRL_RST[5:4];
      route <= `EEP_ROUTE_RST;
      emu_cfg <= `EEP_EMU_RST;
      lib_addr <= 10'h000;
      edid_addr <= 11'h000;
    end else if (sw_wr) begin
      case (bus_addr)
        `EEP_REG_CTRL: begin
          hdcp_en <= bus_wdata[`EEP_CTRL_HDCP_LSB +: 4];
          out_always <= bus_wdata[`EEP_CTRL_MODE_LSB +: 2];
        end
        `EEP_REG_ROUTE: route <= bus_wdata[3:0];
        `EEP_REG_EMU: emu_cfg <= bus_wdata[15:0];
        `EEP_REG_LIB_ADDR: lib_addr <= bus_wdata[9:0];
        `EEP_REG_LIB_DATA: lib_addr <= lib_addr + 10'h001;
        `EEP_REG_EDID_ADDR: edid_addr <= bus_wdata[10:0];
        default: lib_addr <= lib_addr;
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      case (bus_addr)
        `EEP_REG_CTRL: bus_rdata <= {26'h000_0000, out_always, hdcp_en};
        `EEP_REG_ROUTE: bus_rdata <= {28'h000_0000, route};
        `EEP_REG_EMU: bus_rdata <= {16'h0000, emu_cfg};
        `EEP_REG_STATUS: bus_rdata <= {15'h0000, commit_req, out_alert, sink_valid,
                                       hpd, pending, 3'b000, (state == ST_COPY)};
        `EEP_REG_LIB_ADDR: bus_rdata <= {22'h00_0000, lib_addr};
        `EEP_REG_LIB_DATA: bus_rdata <= {24'h00_0000, lib_store[lib_addr]};
        `EEP_REG_EDID_ADDR: bus_rdata <= {21'h00_0000, edid_addr};
        `EEP_REG_EDID_DATA: begin
          if (edid_addr[10]) begin
            bus_rdata <= {24'h00_0000, sink_store[edid_addr[8:0]]};
          end else begin
            bus_rdata <= {24'h00_0000, in_store[edid_addr[9:0]]};
          end
        end
        default: bus_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // pin synchronisers for encryption and sink compliance
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enc_meta <= 4'h0;
      enc_sync <= 4'h0;
      sink_meta <= 2'b00;
      sink_sync <= 2'b00;
    end else begin
      enc_meta <= in_encrypted;
      enc_sync <= enc_meta;
      sink_meta <= sink_hdcp_ok;
      sink_sync <= sink_meta;
    end
  end

  // hdcp policy per output
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_hdcp_capable <= 4'h0;
      out_encrypt <= 2'b00;
      out_alert <= 2'b00;
    end else begin
      src_hdcp_capable <= hdcp_en; // R10 R12
      for (j = 0; j < 2; j = j + 1) begin
        if (!sink_sync[j]) begin
          out_encrypt[j] <= 1'b0; // R09
          out_alert[j] <= enc_sync[route[j*2 +: 2]]; // R09
        end else begin
          // automatic mode passes clear content in the clear
          out_encrypt[j] <= out_always[j] | enc_sync[route[j*2 +: 2]]; // R11
          out_alert[j] <= 1'b0;
        end
      end
    end
  end

endmodule // eep_top

// File: eep_sva.sv
// port assertions for the edid emulation and hdcp policy block
`timescale 1ns/1ps
module eep_sva #(
  parameter TICK_CYCLES = 4
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire ddc_rd,
  input wire [7:0] ddc_data,
  input wire cap_ready,
  input wire [3:0] hpd,
  input wire [3:0] src_hdcp_capable,
  input wire [1:0] sink_hdcp_ok,
  input wire [1:0] out_encrypt,
  input wire [1:0] out_alert
);
  integer low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // only input 0 is counted to keep the helper small
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 0;
    end else if (hpd[0]) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  a_hpd_low_len: assert property ($rose(hpd[0]) |-> low_cnt >= 1999 * TICK_CYCLES)
    else $error("hot-plug low period too short");
  a_cap_follow: assert property (bus_wr && bus_addr == 8'h00 |=> ##1
    src_hdcp_capable == $past(bus_wdata[3:0], 2)) else $error("capability not following");
  a_no_enc_bad: assert property (!sink_hdcp_ok[0] [*4] |-> !out_encrypt[0])
    else $error("encrypting toward non-compliant display");
  a_no_enc_bad1: assert property (!sink_hdcp_ok[1] [*4] |-> !out_encrypt[1])
    else $error("encrypting toward non-compliant display");
  a_alert_ok_sink: assert property (sink_hdcp_ok[0] [*4] |-> !out_alert[0])
    else $error("alert toward compliant display");
  a_alert_excl: assert property ((out_alert & out_encrypt) == 2'h0)
    else $error("alert and encryption together");
  a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_ddc_hold: assert property (!ddc_rd |=> $stable(ddc_data))
    else $error("edid byte moved without a read");
  a_cap_back: assert property ($fell(cap_ready) |-> ##[1:600] cap_ready)
    else $error("capture buffer stuck busy");
  c_reload: cover property ($fell(hpd[0]));
  c_alert: cover property ($rose(out_alert[0]));
  c_commit: cover property ($fell(cap_ready));
endmodule // eep_sva

// File: eep_sink_model.sv
// display-side model: delivers a captured edid and hdcp compliance
`timescale 1ns/1ps
module eep_sink_model (
  input wire clk,
  input wire start,
  input wire out_sel,
  input wire [7:0] image [0:255],
  input wire [1:0] compliant,
  input wire cap_ready,
  output logic cap_valid,
  output logic cap_output,
  output logic [7:0] cap_addr,
  output logic [7:0] cap_data,
  output logic cap_done,
  output wire [1:0] sink_hdcp_ok
);
  integer k;
  assign sink_hdcp_ok = compliant;
  initial begin
    cap_valid = 0;
    cap_output = 0;
    cap_addr = 8'h00;
    cap_data = 8'h00;
    cap_done = 0;
    forever begin
      @(posedge clk);
      if (start) begin
        while (!cap_ready) begin
          @(posedge clk);
        end
        for (k = 0; k < 256; k++) begin
          cap_valid <= 1;
          cap_addr <= k[7:0];
          cap_data <= image[k];
          @(posedge clk);
        end
        // released lanes show the inverse so a stale sample is caught
        cap_valid <= 0;
        cap_addr <= ~cap_addr;
        cap_data <= ~cap_data;
        cap_output <= out_sel;
        cap_done <= 1;
        @(posedge clk);
        cap_done <= 0;
        cap_output <= ~out_sel;
      end
    end
  end
endmodule // eep_sink_model

// File: edid_emulation_hdcp_policy_tb_top.sv
// self-checking bench for the edid emulation and hdcp policy block
`timescale 1ns/1ps
`include "eep_consts.vh"
module edid_emulation_hdcp_policy_tb_top;
  logic clk = 0;
  logic rstn = 0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 0;
  logic bus_rd = 0;
  logic ddc_rd = 0;
  logic [1:0] ddc_input = 2'h0;
  logic [7:0] ddc_addr = 8'h00;
  logic [3:0] in_encrypted = 4'h0;
  logic start = 0;
  logic out_sel = 0;
  logic [1:0] compliant = 2'h0;
  wire [31:0] bus_rdata;
  wire [7:0] ddc_data, cap_addr, cap_data;
  wire cap_valid, cap_output, cap_done, cap_ready;
  wire [3:0] hpd, src_hdcp_capable;
  wire [1:0] sink_hdcp_ok, out_encrypt, out_alert;
  logic [7:0] img [0:255];
  logic [7:0] ref_b [0:255];
  logic [7:0] lib [0:511];
  integer seed = 32'h0000_c5de;
  integer miscompares = 0;
  integer compares = 0;
  integer i, n, c;
  logic [31:0] d;
  logic [7:0] sum;
  logic [1:0] ex;

  always #4 clk = ~clk;

  eep_top #(.TICK_CYCLES(4)) dut (
    .clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ddc_rd(ddc_rd),
    .ddc_input(ddc_input), .ddc_addr(ddc_addr), .ddc_data(ddc_data),
    .cap_valid(cap_valid), .cap_output(cap_output), .cap_addr(cap_addr),
    .cap_data(cap_data), .cap_done(cap_done), .cap_ready(cap_ready), .hpd(hpd),
    .src_hdcp_capable(src_hdcp_capable), .in_encrypted(in_encrypted),
    .sink_hdcp_ok(sink_hdcp_ok), .out_encrypt(out_encrypt), .out_alert(out_alert));
  eep_sink_model disp (
    .clk(clk), .start(start), .out_sel(out_sel), .image(img), .compliant(compliant),
    .cap_ready(cap_ready), .cap_valid(cap_valid), .cap_output(cap_output),
    .cap_addr(cap_addr), .cap_data(cap_data), .cap_done(cap_done),
    .sink_hdcp_ok(sink_hdcp_ok));

  task results;
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_wr <= 1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clk);
    bus_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    bus_rd <= 1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 0;
    #1 d = bus_rdata;
  endtask
  task cmp_store(input logic [1:0] p);
    integer k;
    for (k = 0; k < 256; k++) begin
      @(posedge clk);
      ddc_rd <= 1;
      ddc_input <= p;
      ddc_addr <= k[7:0];
      @(posedge clk);
      ddc_rd <= 0;
      #1 chk({24'h00_0000, ddc_data}, {24'h00_0000, ref_b[k]});
    end
  endtask
  task sink_chk;
    integer k;
    for (k = 0; k < 256; k += 37) begin
      wr(`EEP_REG_EDID_ADDR, 32'h0000_0500 + k);
      rd(`EEP_REG_EDID_DATA);
      chk(d, {24'h00_0000, ref_b[k]});
    end
  endtask
  task wait_hpd(input integer p, input logic lvl, input integer lim);
    n = 0;
    while (hpd[p] !== lvl && n < lim) begin
      @(posedge clk);
      n = n + 1;
    end
  endtask
  task load_ref(input integer base);
    for (i = 0; i < 256; i++) begin
      ref_b[i] = base < 0 ? img[i] : lib[base + i];
    end
  endtask
  task capture(input logic bad);
    sum = 8'h00;
    for (i = 0; i < 256; i++) begin
      img[i] = $random(seed);
    end
    img[0] = 8'h00;
    img[1] = 8'hff;
    for (i = 0; i < 127; i++) begin
      sum = sum + img[i];
    end
    // a forced checksum slip makes the display's edid invalid
    img[127] = 8'h00 - sum + {7'h00, bad};
    out_sel <= 1;
    start <= 1;
    @(posedge clk);
    start <= 0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    chk(hpd, 4'hf);
    rstn <= 1;
    @(posedge clk);
    #1 chk(src_hdcp_capable, 4'hf);
    for (c = 0; c < 3; c++) begin
      n = $random(seed);
      wr(`EEP_REG_CTRL, {28'h000_0000, n[3:0]});
      @(posedge clk);
      #1 chk(src_hdcp_capable, n[3:0]);
    end
    wr(`EEP_REG_LIB_ADDR, 32'h0000_0000);
    for (c = 0; c < 512; c++) begin
      lib[c] = $random(seed);
      wr(`EEP_REG_LIB_DATA, {24'h00_0000, lib[c]});
    end
    wr(`EEP_REG_EMU, 32'h0000_0100);
    wr(`EEP_REG_CMD, 32'h0000_0004);
    wr(`EEP_REG_CMD, 32'h0000_0006);
    wait_hpd(2, 1'b0, 1200);
    chk({hpd[3], hpd[2], hpd[1]}, 3'b101);
    load_ref(0);
    cmp_store(0);
    load_ref(256);
    cmp_store(2);
    wr(`EEP_REG_CMD, 32'h0000_0006);
    wait_hpd(2, 1'b1, 9000);
    chk(n >= 8200 && n <= 8300, 1'b1);
    wr(`EEP_REG_EMU, 32'h0000_9100);
    capture(1'b0);
    wait_hpd(3, 1'b0, 1200);
    chk(hpd[3], 1'b0);
    load_ref(-1);
    cmp_store(3);
    sink_chk();
    wait_hpd(3, 1'b1, 9000);
    capture(1'b1);
    repeat (900) @(posedge clk);
    chk(hpd[3], 1'b1);
    cmp_store(3);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    sink_chk();
    for (c = 0; c < 16; c++) begin
      wr(`EEP_REG_CTRL, {26'h000_0000, 1'b0, c[2], 3'h7, c[3]});
      compliant <= {1'b1, c[1]};
      repeat (3) @(posedge clk);
      in_encrypted <= {3'h0, c[0] & src_hdcp_capable[0]};
      repeat (5) @(posedge clk);
      ex = c[1] ? {c[2] | (c[0] & c[3]), 1'b0} : {1'b0, c[0] & c[3]};
      #1 chk({out_encrypt[0], out_alert[0]}, ex);
    end
    results;
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares = miscompares + 1;
    results;
  end
endmodule // edid_emulation_hdcp_policy_tb_top

bind eep_top eep_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ddc_rd(ddc_rd), .ddc_data(ddc_data),
  .cap_ready(cap_ready), .hpd(hpd), .src_hdcp_capable(src_hdcp_capable),
  .sink_hdcp_ok(sink_hdcp_ok), .out_encrypt(out_encrypt), .out_alert(out_alert));
